// ===== rtl/axis_pos_pkg.sv
package axis_pos_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  OFS_CMD_POS  = 5'h00;
	localparam logic [4:0]  OFS_ENC_POS  = 5'h04;
	localparam logic [4:0]  OFS_CMP_HI   = 5'h08;
	localparam logic [4:0]  OFS_CMP_LO   = 5'h0C;
	localparam logic [4:0]  OFS_CFG_B    = 5'h10;
	localparam logic [4:0]  OFS_CFG_C    = 5'h14;
	localparam logic [4:0]  OFS_CMP_STAT = 5'h18;
	localparam logic [4:0]  OFS_LIM_STAT = 5'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          BIT_SLIM_HI  = 0;
	localparam int          BIT_SLIM_LO  = 1;
	localparam int          BIT_ENC_UPDN = 2;
	localparam int          BIT_CMP_SRC  = 5;
	localparam int          BIT_RING     = 6;
	localparam int          BIT_FLAG_HI  = 0;
	localparam int          BIT_FLAG_LO  = 1;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] POS_RESET    = 32'h0000_0000;
	localparam logic [31:0] CMP_RESET    = 32'h0000_0000;
	localparam logic [7:0]  CFG_RESET    = 8'h00;
	localparam int          SYS_CLK_DIV  = 2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic pulse;
		logic negative;
		logic driving;
	} drive_t;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
	} enc_pins_t;

	typedef struct packed {
		apb_rsp_t    rsp;
		logic [31:0] cmd_pos;
		logic [31:0] enc_pos;
		logic [31:0] cmp_hi;
		logic [31:0] cmp_lo;
		logic [7:0]  cfg_b;
		logic [7:0]  cfg_c;
		logic [1:0]  cmp_flags;
		logic [1:0]  lim_flags;
		logic [1:0]  enc_meta;
		logic [1:0]  enc_sync;
		logic [1:0]  enc_prev;
		logic        tick;
		logic        decel;
	} axis_state_t;

endpackage

// ===== rtl/axis_position_compare_ring.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module axis_position_compare_ring
(
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  reset_i,
	// Register bus
	input  wire axis_pos_pkg::apb_req_t apb_i,
	output axis_pos_pkg::apb_rsp_t     apb_o,
	// Drive pulses from the pulse generator (same clock)
	input  wire axis_pos_pkg::drive_t   drive_i,
	// Encoder pins (asynchronous)
	input  wire axis_pos_pkg::enc_pins_t enc_i,
	// Stop request and half-rate tick
	output logic                       decel_stop_o,
	output logic                       sys_tick_o
);

	// ----------------------------------------------------------------
	// State and next state
	// ----------------------------------------------------------------
	axis_pos_pkg::axis_state_t s;
	axis_pos_pkg::axis_state_t next_s;

	logic        setup;
	logic        host_wr;
	logic        ring_on;
	logic [31:0] sel_pos;
	logic        over_hi;
	logic        under_lo;
	logic [1:0]  enc_chg;
	logic        enc_cnt;
	logic        enc_up;
	logic        slim_hi_en;
	logic        slim_lo_en;

	// Wrap-aware one step; plain 32-bit arithmetic wraps by itself
	function automatic logic [31:0] step_count
	(
		input logic [31:0] value,
		input logic        up,
		input logic        ring,
		input logic [31:0] maximum
	);
		logic [31:0] res;
		if (up)
			res = (ring && value == maximum) ? 32'h0000_0000
				: value + 32'h0000_0001;
		else
			res = (ring && value == 32'h0000_0000) ? maximum
				: value - 32'h0000_0001;
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Decode of bus, configuration and compare
	// ----------------------------------------------------------------
	assign setup      = apb_i.psel && !apb_i.penable;
	assign host_wr    = apb_i.psel && apb_i.penable && apb_i.pwrite
		&& s.rsp.pready;
	assign ring_on    = s.cfg_c[axis_pos_pkg::BIT_RING];
	assign sel_pos    = s.cfg_b[axis_pos_pkg::BIT_CMP_SRC]
		? s.enc_pos : s.cmd_pos;
	// Signed compare covers the full two's complement range
	assign over_hi    = $signed(sel_pos) > $signed(s.cmp_hi);
	assign under_lo   = $signed(sel_pos) < $signed(s.cmp_lo);
	assign slim_hi_en = s.cfg_b[axis_pos_pkg::BIT_SLIM_HI];
	assign slim_lo_en = s.cfg_b[axis_pos_pkg::BIT_SLIM_LO];

	// Encoder event decode, only at the half-rate tick
	assign enc_chg = s.enc_sync ^ s.enc_prev;
	always_comb
	begin
		enc_cnt = 1'b0;
		enc_up  = 1'b0;
		if (s.cfg_b[axis_pos_pkg::BIT_ENC_UPDN])
		begin
			// Separate up and down pulses, counted on rising edges
			enc_cnt = s.tick && ((s.enc_sync[1] && !s.enc_prev[1])
				^ (s.enc_sync[0] && !s.enc_prev[0]));
			enc_up  = s.enc_sync[1] && !s.enc_prev[1];
		end
		else
		begin
			// Quadrature, four counts per cycle; a double jump is noise
			enc_cnt = s.tick && (enc_chg[1] ^ enc_chg[0]);
			enc_up  = s.enc_sync[1] ^ s.enc_prev[0];
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;

		// Half-rate operating tick
		next_s.tick = !s.tick;

		// Two-stage synchroniser, then edge history at the tick
		next_s.enc_meta = {enc_i.phase_a, enc_i.phase_b};
		next_s.enc_sync = s.enc_meta;
		if (s.tick)
			next_s.enc_prev = s.enc_sync;

		// Position counting; ring uses compare values as maxima
		if (drive_i.pulse)
			next_s.cmd_pos = step_count(s.cmd_pos, !drive_i.negative,
				ring_on, s.cmp_hi);
		if (enc_cnt)
			next_s.enc_pos = step_count(s.enc_pos, enc_up,
				ring_on, s.cmp_lo);

		// Host writes take effect at the access edge and beat counting
		if (host_wr)
		begin
			case (apb_i.paddr)
				axis_pos_pkg::OFS_CMD_POS:
					next_s.cmd_pos = apb_i.pwdata;
				axis_pos_pkg::OFS_ENC_POS:
					next_s.enc_pos = apb_i.pwdata;
				axis_pos_pkg::OFS_CMP_HI:
					next_s.cmp_hi = apb_i.pwdata;
				axis_pos_pkg::OFS_CMP_LO:
					next_s.cmp_lo = apb_i.pwdata;
				axis_pos_pkg::OFS_CFG_B:
					next_s.cfg_b = apb_i.pwdata[7:0];
				axis_pos_pkg::OFS_CFG_C:
					next_s.cfg_c = apb_i.pwdata[7:0];
				default:
					next_s.cfg_c = s.cfg_c;
			endcase
		end

		// Compare flags follow the selected count
		next_s.cmp_flags[axis_pos_pkg::BIT_FLAG_HI] = over_hi;
		next_s.cmp_flags[axis_pos_pkg::BIT_FLAG_LO] = under_lo;

		// Limit flags latch while driving, drop once back inside
		if (slim_hi_en && drive_i.driving && over_hi)
			next_s.lim_flags[axis_pos_pkg::BIT_FLAG_HI] = 1'b1;
		else if (!over_hi)
			next_s.lim_flags[axis_pos_pkg::BIT_FLAG_HI] = 1'b0;
		if (slim_lo_en && drive_i.driving && under_lo)
			next_s.lim_flags[axis_pos_pkg::BIT_FLAG_LO] = 1'b1;
		else if (!under_lo)
			next_s.lim_flags[axis_pos_pkg::BIT_FLAG_LO] = 1'b0;

		// Stop request to the pulse generator while a limit is crossed
		next_s.decel = drive_i.driving
			&& ((slim_hi_en && over_hi)
			|| (slim_lo_en && under_lo));

		// Slave answers in the cycle after setup, no wait states
		next_s.rsp.pready  = setup;
		next_s.rsp.pslverr = 1'b0;
		next_s.rsp.prdata  = 32'h0000_0000;
		if (setup)
		begin
			case (apb_i.paddr)
				axis_pos_pkg::OFS_CMD_POS:
					next_s.rsp.prdata = s.cmd_pos;
				axis_pos_pkg::OFS_ENC_POS:
					next_s.rsp.prdata = s.enc_pos;
				axis_pos_pkg::OFS_CMP_HI:
					next_s.rsp.prdata = s.cmp_hi;
				axis_pos_pkg::OFS_CMP_LO:
					next_s.rsp.prdata = s.cmp_lo;
				axis_pos_pkg::OFS_CFG_B:
					next_s.rsp.prdata = {24'h00_0000, s.cfg_b};
				axis_pos_pkg::OFS_CFG_C:
					next_s.rsp.prdata = {24'h00_0000, s.cfg_c};
				axis_pos_pkg::OFS_CMP_STAT:
					next_s.rsp.prdata = {30'h0, s.cmp_flags};
				axis_pos_pkg::OFS_LIM_STAT:
					next_s.rsp.prdata = {30'h0, s.lim_flags};
				default:
					next_s.rsp.pslverr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s           <= '0;
			s.cmd_pos   <= axis_pos_pkg::POS_RESET;
			s.enc_pos   <= axis_pos_pkg::POS_RESET;
			s.cmp_hi    <= axis_pos_pkg::CMP_RESET;
			s.cmp_lo    <= axis_pos_pkg::CMP_RESET;
			s.cfg_b     <= axis_pos_pkg::CFG_RESET;
			s.cfg_c     <= axis_pos_pkg::CFG_RESET;
		end
		else
			s <= next_s;
	end

	// Outputs straight from state
	assign apb_o        = s.rsp;
	assign decel_stop_o = s.decel;
	assign sys_tick_o   = s.tick;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_pos_pulse;
		drive_i.pulse && !drive_i.negative && !host_wr;
	endsequence

	sequence s_neg_pulse;
		drive_i.pulse && drive_i.negative && !host_wr;
	endsequence

	sequence s_ring_top;
		s_pos_pulse ##0 ring_on && s.cmd_pos == s.cmp_hi;
	endsequence

	chk_cmd_count_up: assert property (
		s_pos_pulse ##0 !(ring_on && s.cmd_pos == s.cmp_hi)
		|=> s.cmd_pos == $past(s.cmd_pos) + 32'h0000_0001)
		else $error("commanded count did not step up");

	chk_cmd_count_down: assert property (
		s_neg_pulse ##0 !(ring_on && s.cmd_pos == 32'h0000_0000)
		|=> s.cmd_pos == $past(s.cmd_pos) - 32'h0000_0001)
		else $error("commanded count did not step down");

	chk_ring_wrap_top: assert property (
		s_ring_top |=> s.cmd_pos == 32'h0000_0000)
		else $error("ring count did not wrap to zero");

	chk_ring_wrap_zero: assert property (
		s_neg_pulse ##0 ring_on && s.cmd_pos == 32'h0000_0000
		|=> s.cmd_pos == $past(s.cmp_hi))
		else $error("ring count did not wrap to maximum");

	chk_upper_cmp_flag: assert property (
		##1 s.cmp_flags[0] == ($signed($past(sel_pos))
			> $signed($past(s.cmp_hi))))
		else $error("upper compare flag wrong");

	chk_lower_cmp_flag: assert property (
		##1 s.cmp_flags[1] == ($signed($past(sel_pos))
			< $signed($past(s.cmp_lo))))
		else $error("lower compare flag wrong");

	chk_soft_hi_set: assert property (
		slim_hi_en && drive_i.driving && over_hi
		|=> s.lim_flags[0] && decel_stop_o)
		else $error("upper soft limit not taken");

	chk_soft_hi_clear: assert property (
		!over_hi |=> !s.lim_flags[0])
		else $error("upper soft limit flag stuck");

	chk_soft_lo_set: assert property (
		slim_lo_en && drive_i.driving && under_lo
		|=> s.lim_flags[1] && decel_stop_o)
		else $error("lower soft limit not taken");

	chk_host_overwrite: assert property (
		host_wr && apb_i.paddr == axis_pos_pkg::OFS_ENC_POS
		|=> s.enc_pos == $past(apb_i.pwdata))
		else $error("encoder count write lost");

	chk_half_rate_tick: assert property (
		sys_tick_o |=> !sys_tick_o ##1 sys_tick_o)
		else $error("operating tick not half rate");

	chk_apb_answer: assert property (
		setup |=> apb_o.pready ##1 !apb_o.pready)
		else $error("bus answer timing wrong");

	chk_soft_lo_clear: assert property (
		!under_lo |=> !s.lim_flags[1])
		else $error("lower soft limit flag stuck");

	chk_limit_needs_drive: assert property (
		$rose(s.lim_flags[0]) |-> $past(drive_i.driving))
		else $error("upper soft limit set while idle");

	chk_decel_idle: assert property (
		!drive_i.driving |=> !decel_stop_o)
		else $error("stop requested while not driving");

	// Encoder step not overridden by a host write in the same cycle
	sequence s_enc_clean;
		enc_cnt && !host_wr;
	endsequence

	chk_enc_count_up: assert property (
		s_enc_clean ##0 (enc_up && !ring_on)
		|=> s.enc_pos == $past(s.enc_pos) + 32'h0000_0001)
		else $error("encoder count did not step up");

	chk_enc_count_down: assert property (
		s_enc_clean ##0 (!enc_up && !ring_on)
		|=> s.enc_pos == $past(s.enc_pos) - 32'h0000_0001)
		else $error("encoder count did not step down");

	chk_enc_ring_top: assert property (
		s_enc_clean ##0 (enc_up && ring_on && s.enc_pos == s.cmp_lo)
		|=> s.enc_pos == 32'h0000_0000)
		else $error("encoder ring did not wrap to zero");

	chk_enc_ring_zero: assert property (
		s_enc_clean ##0 (!enc_up && ring_on && s.enc_pos == 32'h0000_0000)
		|=> s.enc_pos == $past(s.cmp_lo))
		else $error("encoder ring did not wrap to maximum");

	chk_cmd_hold: assert property (
		!drive_i.pulse && !host_wr |=> $stable(s.cmd_pos))
		else $error("commanded count moved without a pulse");

	chk_cmp_hi_write: assert property (
		host_wr && apb_i.paddr == axis_pos_pkg::OFS_CMP_HI
		|=> s.cmp_hi == $past(apb_i.pwdata))
		else $error("upper compare write lost");

	chk_error_with_ready: assert property (
		apb_o.pslverr |-> apb_o.pready)
		else $error("bus error without ready");

endmodule

// ===== verif/axis_position_compare_ring_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin num_errors++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, g, x); end end
module axis_position_compare_ring_tb_top;
	logic                    mclk_i;
	logic                    reset_i;
	axis_pos_pkg::apb_req_t  apb_i;
	axis_pos_pkg::apb_rsp_t  apb_o;
	axis_pos_pkg::drive_t    drive_i;
	axis_pos_pkg::enc_pins_t enc_i;
	logic                    decel_stop_o;
	logic                    sys_tick_o;
	int                      num_errors;
	int                      comparisons;
	int                      cycles;
	logic [31:0]             rd;
	logic [31:0]             pos;
	logic [31:0]             oth;
	logic [31:0]             sel;
	logic [31:0]             hi;
	logic [31:0]             lo;
	logic [31:0]             e;
	logic                    err;
	logic [31:0]             starts [4];

	axis_position_compare_ring u_axis_position_compare_ring (.mclk_i(mclk_i),
		.reset_i(reset_i), .apb_i(apb_i), .apb_o(apb_o), .drive_i(drive_i),
		.enc_i(enc_i), .decel_stop_o(decel_stop_o), .sys_tick_o(sys_tick_o));
	enc_pulse_source u_enc_pulse_source (.mclk_i(mclk_i), .enc_o(enc_i));

	always #5 mclk_i = ~mclk_i;

	// Hang guard, well above the expected run length
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	// Position step as the counter should take it
	function automatic logic [31:0] nxt(logic [31:0] v, logic up, logic ring,
		logic [31:0] mx);
		if (ring)
			return up ? ((v == mx) ? 32'h0 : v + 1) : ((v == 0) ? mx : v - 1);
		return up ? v + 1 : v - 1;
	endfunction

	// One APB transfer; request held until pready is sampled
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		apb_i <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
		@(posedge mclk_i);
		apb_i.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (apb_o.pready !== 1'b1);
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
		// Slave is wait-free: ready in the first access cycle
		`CHK(n, 1)
	endtask

	task automatic pulse(input logic neg);
		@(posedge mclk_i);
		drive_i.pulse <= 1'b1;
		drive_i.negative <= neg;
		@(posedge mclk_i);
		drive_i.pulse <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		mclk_i = 1'b0;
		reset_i = 1'b1;
		apb_i = '0;
		drive_i = '0;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		void'($urandom(32'h24DD1A4C));
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, 5'(i * 4), 32'h0);
			`CHK(rd, 32'h0)
		end
		bus(1'b0, 5'h01, 32'h0);
		`CHK(err, 1'b1)
		// Half-rate tick flips every clock
		@(posedge mclk_i);
		e[0] = sys_tick_o;
		@(posedge mclk_i);
		`CHK(sys_tick_o ^ e[0], 1'b1)
		// Counting across the signed and unsigned boundaries
		starts = '{32'h7FFFFFFF, 32'h0, 32'hFFFFFFFF, $urandom};
		foreach (starts[k])
		begin
			pos = starts[k];
			bus(1'b1, axis_pos_pkg::OFS_CMD_POS, pos);
			for (int i = 0; i < 6; i++)
			begin
				e = (i == 0) ? 32'(k & 1) : $urandom;
				pulse(e[0]);
				pos = nxt(pos, !e[0], 1'b0, 32'h0);
			end
			bus(1'b0, axis_pos_pkg::OFS_CMD_POS, 32'h0);
			`CHK(rd, pos)
		end
		// Compare flags with random source and bounds
		for (int i = 0; i < 12; i++)
		begin
			pos = $urandom;
			oth = $urandom;
			e = $urandom;
			sel = e[0] ? oth : pos;
			hi = (i % 3 == 0) ? sel : $urandom;
			lo = (i % 3 == 1) ? sel : $urandom;
			bus(1'b1, axis_pos_pkg::OFS_CMD_POS, pos);
			bus(1'b1, axis_pos_pkg::OFS_ENC_POS, oth);
			bus(1'b1, axis_pos_pkg::OFS_CMP_HI, hi);
			bus(1'b1, axis_pos_pkg::OFS_CMP_LO, lo);
			bus(1'b1, axis_pos_pkg::OFS_CFG_B, e[0] ? 32'h20 : 32'h0);
			bus(1'b0, axis_pos_pkg::OFS_CMP_HI, 32'h0);
			`CHK(rd, hi)
			bus(1'b0, axis_pos_pkg::OFS_CMP_LO, 32'h0);
			`CHK(rd, lo)
			e[1] = $signed(sel) > $signed(hi);
			e[2] = $signed(sel) < $signed(lo);
			bus(1'b0, axis_pos_pkg::OFS_CMP_STAT, 32'h0);
			`CHK(rd, {30'h0, e[2], e[1]})
		end
		// Soft limits while driving
		drive_i.driving <= 1'b1;
		bus(1'b1, axis_pos_pkg::OFS_CMP_HI, 32'h0000000A);
		bus(1'b1, axis_pos_pkg::OFS_CMP_LO, 32'hFFFFFFFB);
		bus(1'b1, axis_pos_pkg::OFS_CFG_B, 32'h3);
		bus(1'b1, axis_pos_pkg::OFS_CMD_POS, 32'h0000000B);
		bus(1'b0, axis_pos_pkg::OFS_LIM_STAT, 32'h0);
		`CHK(rd, 32'h1)
		`CHK(decel_stop_o, 1'b1)
		bus(1'b1, axis_pos_pkg::OFS_CMD_POS, 32'h0000000A);
		bus(1'b0, axis_pos_pkg::OFS_LIM_STAT, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(decel_stop_o, 1'b0)
		bus(1'b1, axis_pos_pkg::OFS_CMD_POS, 32'hFFFFFFFA);
		bus(1'b0, axis_pos_pkg::OFS_LIM_STAT, 32'h0);
		`CHK(rd, 32'h2)
		`CHK(decel_stop_o, 1'b1)
		drive_i.driving <= 1'b0;
		// Ring mode on both counters, soft limits off first
		bus(1'b1, axis_pos_pkg::OFS_CFG_B, 32'h0);
		bus(1'b1, axis_pos_pkg::OFS_CMP_HI, 32'h0000270F);
		bus(1'b1, axis_pos_pkg::OFS_CMP_LO, 32'h00000003);
		bus(1'b1, axis_pos_pkg::OFS_CFG_C, 32'h40);
		`CHK(decel_stop_o, 1'b0)
		bus(1'b1, axis_pos_pkg::OFS_CMD_POS, 32'h0000270F);
		bus(1'b1, axis_pos_pkg::OFS_ENC_POS, 32'h0);
		pulse(1'b0);
		bus(1'b0, axis_pos_pkg::OFS_CMD_POS, 32'h0);
		`CHK(rd, 32'h0)
		pulse(1'b1);
		bus(1'b0, axis_pos_pkg::OFS_CMD_POS, 32'h0);
		`CHK(rd, 32'h0000270F)
		u_enc_pulse_source.step(1'b1, 1'b0);
		bus(1'b0, axis_pos_pkg::OFS_ENC_POS, 32'h0);
		`CHK(rd, 32'h3)
		u_enc_pulse_source.step(1'b0, 1'b0);
		bus(1'b0, axis_pos_pkg::OFS_ENC_POS, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b1, axis_pos_pkg::OFS_CFG_C, 32'h0);
		// Encoder counting, up/down mode then quadrature
		for (int m = 1; m >= 0; m--)
		begin
			pos = $urandom;
			bus(1'b1, axis_pos_pkg::OFS_CFG_B, (m == 1) ? 32'h4 : 32'h0);
			bus(1'b1, axis_pos_pkg::OFS_ENC_POS, pos);
			for (int i = 0; i < 10; i++)
			begin
				e = $urandom;
				u_enc_pulse_source.step(e[0], m[0]);
				pos = nxt(pos, !e[0], 1'b0, 32'h0);
			end
			bus(1'b0, axis_pos_pkg::OFS_ENC_POS, 32'h0);
			`CHK(rd, pos)
		end
		wrap_up();
	end
endmodule

// ===== verif/enc_pulse_source.sv
`timescale 1ns/10ps
// ----------------------------------------
// Encoder pulse source
// ----------------------------------------
module enc_pulse_source
(
	// Clock
	input  wire logic               mclk_i,
	// Encoder pins
	output axis_pos_pkg::enc_pins_t enc_o
);
	logic [1:0] phase_idx;

	// Idle low, so the first step is a clean edge
	initial
	begin
		phase_idx = 2'h0;
		enc_o = '0;
	end

	// One count; levels held six clocks, above the two-clock minimum
	task automatic step(input logic down, input logic updn);
		@(posedge mclk_i);
		if (updn)
		begin
			enc_o <= down ? 2'h1 : 2'h2;
			repeat (6) @(posedge mclk_i);
			enc_o <= 2'h0;
		end
		else
		begin
			phase_idx = down ? phase_idx - 2'h1 : phase_idx + 2'h1;
			enc_o <= {phase_idx[1] ^ phase_idx[0], phase_idx[1]};
		end
		repeat (6) @(posedge mclk_i);
	endtask
endmodule
